/* File: include/spu_defines.svh */
/*
  Offsets, field positions, reset values and timing figures of the serial port block.
  Assumes it is included by bare name from files that need these constants.
*/
`ifndef SPU_DEFINES_SVH
`define SPU_DEFINES_SVH

`define SPU_OFF_DATA    3'h0
`define SPU_OFF_IER     3'h1
`define SPU_OFF_FIFO    3'h2
`define SPU_OFF_LCR     3'h3
`define SPU_OFF_MCR     3'h4
`define SPU_OFF_LSR     3'h5
`define SPU_OFF_MSR     3'h6
`define SPU_OFF_SCRATCH 3'h7

`define SPU_LCR_BREAK   6
`define SPU_LCR_DIVISOR_ACCESS_SELECT    7
`define SPU_FCR_ENABLE  0
`define SPU_FCR_RXCLR   1
`define SPU_FCR_TXCLR   2
`define SPU_MCR_DTR     0
`define SPU_MCR_RTS     1
`define SPU_LSR_THRE    5
`define SPU_LSR_TEMT    6

`define SPU_TRIG_00     5'h01
`define SPU_TRIG_01     5'h04
`define SPU_TRIG_10     5'h08
`define SPU_TRIG_11     5'h0e

`define SPU_DIV_RESET   16'h000c
`define SPU_BYTE_RESET  8'h00
`define SPU_LAST_BASE   3'h4

`define SPU_CLK_HZ      100000000
`define SPU_BASE_BAUD   115200
`define SPU_CYC_PER_DIV (`SPU_CLK_HZ / `SPU_BASE_BAUD)

`endif

/* File: include/spu_pkg.sv */
/*
  Types shared by the serial port block: line format, received character and states.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package spu_pkg;

  typedef struct packed {
    logic       par_stick;
    logic       par_even;
    logic       par_en;
    logic       stop2;
    logic [1:0] len;
  } spu_frame_type;

  typedef struct packed {
    logic       bi;
    logic       fe;
    logic       pe;
    logic [7:0] data;
  } spu_char_type;

  typedef enum {SER_IDLE, SER_START, SER_DATA, SER_PAR, SER_STOP} spu_ser_state_type;

endpackage

/* File: hdl/spu_tx.sv */
/*
  Serial transmitter: frames one character per start pulse onto the line.
  Assumes start is only pulsed while busy is low and bit_cycles is at least one.
*/
`timescale 1ns/10ps
`default_nettype none
`include "spu_defines.svh"

module spu_tx
  import spu_pkg::*;
#(
  parameter int CW = 26
)(
  input  wire logic          clock,
  input  wire logic          rst_b,
  input  wire logic          start,
  input  wire logic [7:0]    data,
  input  wire spu_frame_type frame,
  input  wire logic [CW-1:0] bit_cycles,
  output logic               txd,
  output logic               busy
);

  spu_ser_state_type state;
  logic [CW-1:0]     cyc;
  logic [2:0]        idx;
  logic [7:0]        sh;
  logic              par;
  logic              stops;
  logic [7:0]        masked;

  assign masked = data & (8'hff >> (2'h3 - frame.len));
  assign busy   = state != SER_IDLE;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= SER_IDLE;
      txd   <= 1'b1;
      cyc   <= '0;
      idx   <= '0;
      sh    <= '0;
      par   <= 1'b0;
      stops <= 1'b0;
    end else if (state == SER_IDLE) begin
      if (start) begin
        sh    <= masked;
        par   <= frame.par_stick ? ~frame.par_even : ((^masked) ^ ~frame.par_even);
        txd   <= 1'b0;
        cyc   <= '0;
        state <= SER_START;
      end
    end else if (cyc != bit_cycles - 1'b1) begin
      cyc <= cyc + 1'b1;
    end else begin
      cyc <= '0;
      case (state)
        SER_START: begin
          txd   <= sh[0];
          sh    <= sh >> 1;
          idx   <= '0;
          state <= SER_DATA;
        end
        SER_DATA: begin
          if (idx == `SPU_LAST_BASE + {1'b0, frame.len}) begin
            txd   <= frame.par_en ? par : 1'b1;
            stops <= frame.stop2;
            state <= frame.par_en ? SER_PAR : SER_STOP;
          end else begin
            txd <= sh[0];
            sh  <= sh >> 1;
            idx <= idx + 1'b1;
          end
        end
        SER_PAR: begin
          txd   <= 1'b1;
          state <= SER_STOP;
        end
        SER_STOP: begin
          if (stops) begin
            stops <= 1'b0;
          end else begin
            state <= SER_IDLE;
          end
        end
        default: state <= SER_IDLE;
      endcase
    end
  end

  chk_start_bit_low: assert property (@(posedge clock) disable iff (!rst_b)
    start && !busy |=> !txd && busy) else $error("start bit not driven low");

endmodule
`default_nettype wire

/* File: hdl/spu_rx.sv */
/*
  Serial receiver: finds a start edge, samples mid-bit and reports one character.
  Assumes rxd is synchronous to clock and idles high.
*/
`timescale 1ns/10ps
`default_nettype none
`include "spu_defines.svh"

module spu_rx
  import spu_pkg::*;
#(
  parameter int CW = 26
)(
  input  wire logic          clock,
  input  wire logic          rst_b,
  input  wire logic          rxd,
  input  wire spu_frame_type frame,
  input  wire logic [CW-1:0] bit_cycles,
  output logic               valid,
  output spu_char_type       char_out
);

  spu_ser_state_type state;
  logic [CW-1:0]     cyc;
  logic [2:0]        idx;
  logic [7:0]        sh;
  logic [7:0]        dat;
  logic              rpar;
  logic              rxd_q;
  logic              expect_par;

  assign dat        = sh >> (2'h3 - frame.len);
  assign expect_par = frame.par_stick ? ~frame.par_even : ((^dat) ^ ~frame.par_even);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state    <= SER_IDLE;
      cyc      <= '0;
      idx      <= '0;
      sh       <= '0;
      rpar     <= 1'b0;
      rxd_q    <= 1'b1;
      valid    <= 1'b0;
      char_out <= '0;
    end else begin
      rxd_q <= rxd;
      valid <= 1'b0;
      case (state)
        SER_IDLE: begin
          // A falling edge is needed, so a held break yields one character only.
          if (rxd_q && !rxd) begin
            cyc   <= '0;
            state <= SER_START;
          end
        end
        SER_START: begin
          if (cyc == (bit_cycles >> 1)) begin
            cyc   <= '0;
            idx   <= '0;
            state <= rxd ? SER_IDLE : SER_DATA;
          end else begin
            cyc <= cyc + 1'b1;
          end
        end
        default: begin
          if (cyc != bit_cycles - 1'b1) begin
            cyc <= cyc + 1'b1;
          end else begin
            cyc <= '0;
            if (state == SER_DATA) begin
              sh <= {rxd, sh[7:1]};
              if (idx == `SPU_LAST_BASE + {1'b0, frame.len}) begin
                state <= frame.par_en ? SER_PAR : SER_STOP;
              end else begin
                idx <= idx + 1'b1;
              end
            end else if (state == SER_PAR) begin
              rpar  <= rxd;
              state <= SER_STOP;
            end else begin
              valid         <= 1'b1;
              char_out.data <= dat;
              char_out.pe   <= frame.par_en && (rpar != expect_par);
              char_out.fe   <= !rxd;
              char_out.bi   <= !rxd && (dat == 8'h00) && !(frame.par_en && rpar);
              state         <= SER_IDLE;
            end
          end
        end
      endcase
    end
  end

endmodule
`default_nettype wire

/* File: hdl/spu_serial_port.sv */
/*
  Byte-wide register block of an asynchronous serial port with FIFOs and modem lines.
  Assumes a host that pulses io_rd or io_wr for one clock with a stable address,
  and modem and serial inputs already synchronous to clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "spu_defines.svh"

////////////////////////////////////////////////////////////////////////////////

// Function
// - All registers are eight bits, bit 0 least significant.
// - Registers decode at offsets 0 to 7 above a switch-chosen base.
// - Line control bit 7 switches offsets 0 and 1 to the divisor.
// - Read at offset 0 returns the oldest received character.
// - Write at offset 0 queues a character for transmission.
// - Divisor access: offset 0 is divisor low byte, offset 1 high byte.
// - Bit rate equals 115200 divided by the divisor.
// - Offset 1 holds four interrupt enable bits.
// - FIFO control bit 0 enables FIFOs; bits 1 and 2 empty them.
// - FIFO control bits 7:6 pick receive trigger of 1, 4, 8 or 14.
// - Line control sets length, stop bits, parity mode and break.
// - Line status bit 5 shows the transmit holding side empty.
// - Line status bit 6 shows holding and shift register both empty.
// - Line status bit 7 shows any erroneous character in receive FIFO.
// - Modem status bits 0 to 3 flag changes and ring trailing edge.
// - Modem status bits 4 to 7 show CTS, DSR, RI, DCD levels.
// - Offset 7 is a scratch byte with no other effect.
module spu_serial_port
  import spu_pkg::*;
#(
  parameter int IOW   = 10,
  parameter int DEPTH = 16
)(
  input  wire logic           clock,
  input  wire logic           rst_b,
  input  wire logic [IOW-1:0] io_addr,
  input  wire logic [IOW-4:0] base_switch,
  input  wire logic           io_wr,
  input  wire logic           io_rd,
  input  wire logic [7:0]     io_wdata,
  output logic      [7:0]     io_rdata,
  input  wire logic           serial_in,
  output logic                serial_out,
  input  wire logic           cts,
  input  wire logic           dsr,
  input  wire logic           ri,
  input  wire logic           dcd,
  output logic                dtr,
  output logic                rts,
  output logic                rx_level_reached
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = 26;

  if (DEPTH < 16 || (1 << AW) != DEPTH || IOW < 4) begin : g_bad_params
    $error("DEPTH must be a power of two of at least 16 and IOW at least 4");
  end

  ////////////////////////////////////////////////////////////////////////////////

  logic [15:0]   div;
  logic [7:0]    ier;
  logic [7:0]    fifo_control;
  logic [7:0]    line_control;
  logic [7:0]    modem_control;
  logic [7:0]    scratch;
  logic [3:0]    msr_delta;
  logic [3:0]    modem_q;
  logic [CW-1:0] bit_cycles;
  logic          overrun;

  logic          hit;
  logic [2:0]    off;
  logic          divisor_access_select;
  logic          wr_hit;
  logic          rd_hit;
  spu_frame_type frame;
  logic [AW:0]   limit;

  assign off    = io_addr[2:0];
  assign hit    = io_addr[IOW-1:3] == base_switch;
  assign wr_hit = io_wr && hit;
  assign rd_hit = io_rd && hit;
  assign divisor_access_select   = line_control[`SPU_LCR_DIVISOR_ACCESS_SELECT];
  assign frame  = spu_frame_type'(line_control[5:0]);
  assign limit  = fifo_control[`SPU_FCR_ENABLE] ? (AW+1)'(DEPTH) : (AW+1)'(1);
  assign dtr    = modem_control[`SPU_MCR_DTR];
  assign rts    = modem_control[`SPU_MCR_RTS];

  // Control registers; each is one byte wide except the 16-bit divisor.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      div     <= `SPU_DIV_RESET;
      ier     <= `SPU_BYTE_RESET;
      fifo_control     <= `SPU_BYTE_RESET;
      line_control     <= `SPU_BYTE_RESET;
      modem_control     <= `SPU_BYTE_RESET;
      scratch <= `SPU_BYTE_RESET;
    end else if (wr_hit) begin
      case (off)
        `SPU_OFF_DATA:    if (divisor_access_select) div[7:0] <= io_wdata;
        `SPU_OFF_IER:     if (divisor_access_select) div[15:8] <= io_wdata; else ier <= {4'h0, io_wdata[3:0]};
        `SPU_OFF_FIFO:    fifo_control <= io_wdata;
        `SPU_OFF_LCR:     line_control <= io_wdata;
        `SPU_OFF_MCR:     modem_control <= io_wdata;
        `SPU_OFF_SCRATCH: scratch <= io_wdata;
        default:          ;
      endcase
    end
  end

  // A zero divisor is served as one rather than stopping the line.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bit_cycles <= CW'(`SPU_DIV_RESET * `SPU_CYC_PER_DIV);
    end else begin
      bit_cycles <= CW'((div == 16'h0000 ? 16'h0001 : div) * `SPU_CYC_PER_DIV);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit side.

  logic [7:0]  tx_mem [DEPTH];
  logic [AW-1:0] tx_rd;
  logic [AW-1:0] tx_wr;
  logic [AW:0] tx_count;
  logic        tx_push;
  logic        tx_pop;
  logic        tx_clear;
  logic        tx_start;
  logic [7:0]  tx_data;
  logic        tx_busy;
  logic        tx_line;

  assign tx_clear = wr_hit && off == `SPU_OFF_FIFO && io_wdata[`SPU_FCR_TXCLR];
  assign tx_push  = wr_hit && off == `SPU_OFF_DATA && !divisor_access_select && tx_count != limit;
  assign tx_pop   = !tx_busy && !tx_start && tx_count != '0;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tx_rd    <= '0;
      tx_wr    <= '0;
      tx_count <= '0;
      tx_start <= 1'b0;
      tx_data  <= '0;
    end else begin
      tx_start <= tx_pop;
      if (tx_pop) tx_data <= tx_mem[tx_rd];
      if (tx_clear) begin
        tx_rd    <= '0;
        tx_wr    <= '0;
        tx_count <= '0;
      end else begin
        if (tx_push) tx_wr <= tx_wr + 1'b1;
        if (tx_pop)  tx_rd <= tx_rd + 1'b1;
        tx_count <= tx_count + {{AW{1'b0}}, tx_push} - {{AW{1'b0}}, tx_pop};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (tx_push) tx_mem[tx_wr] <= io_wdata;
  end

  spu_tx #(.CW(CW)) u_tx (
    .clock      (clock),
    .rst_b      (rst_b),
    .start      (tx_start),
    .data       (tx_data),
    .frame      (frame),
    .bit_cycles (bit_cycles),
    .txd        (tx_line),
    .busy       (tx_busy)
  );

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      serial_out <= 1'b1;
    end else begin
      serial_out <= tx_line && !line_control[`SPU_LCR_BREAK];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receive side.

  spu_char_type  rx_mem [DEPTH];
  logic [AW-1:0] rx_rd;
  logic [AW-1:0] rx_wr;
  logic [AW:0]   rx_count;
  logic          rx_valid;
  spu_char_type  rx_char;
  spu_char_type  rx_head;
  logic          rx_push;
  logic          rx_pop;
  logic          rx_clear;
  logic [DEPTH-1:0] err_vec;
  logic [4:0]    trigger;

  assign rx_clear = wr_hit && off == `SPU_OFF_FIFO && io_wdata[`SPU_FCR_RXCLR];
  assign rx_push  = rx_valid && rx_count != limit;
  assign rx_pop   = rd_hit && off == `SPU_OFF_DATA && !divisor_access_select && rx_count != '0;
  assign rx_head  = rx_count != '0 ? rx_mem[rx_rd] : '0;

  spu_rx #(.CW(CW)) u_rx (
    .clock      (clock),
    .rst_b      (rst_b),
    .rxd        (serial_in),
    .frame      (frame),
    .bit_cycles (bit_cycles),
    .valid      (rx_valid),
    .char_out   (rx_char)
  );

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rx_rd    <= '0;
      rx_wr    <= '0;
      rx_count <= '0;
    end else if (rx_clear) begin
      rx_rd    <= '0;
      rx_wr    <= '0;
      rx_count <= '0;
    end else begin
      if (rx_push) rx_wr <= rx_wr + 1'b1;
      if (rx_pop)  rx_rd <= rx_rd + 1'b1;
      rx_count <= rx_count + {{AW{1'b0}}, rx_push} - {{AW{1'b0}}, rx_pop};
    end
  end

  always_ff @(posedge clock) begin
    if (rx_push) rx_mem[rx_wr] <= rx_char;
  end

  // A character arriving with no room is dropped and only the flag records it.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      overrun <= 1'b0;
    end else begin
      overrun <= (overrun && !(rd_hit && off == `SPU_OFF_LSR)) || (rx_valid && rx_count == limit);
    end
  end

  for (genvar i = 0; i < DEPTH; i++) begin : g_err
    assign err_vec[i] = ({1'b0, AW'(AW'(i) - rx_rd)} < rx_count) &&
                        (rx_mem[i].pe || rx_mem[i].fe || rx_mem[i].bi);
  end

  always_comb begin
    case (fifo_control[7:6])
      2'b00:   trigger = `SPU_TRIG_00;
      2'b01:   trigger = `SPU_TRIG_01;
      2'b10:   trigger = `SPU_TRIG_10;
      default: trigger = `SPU_TRIG_11;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rx_level_reached <= 1'b0;
    end else begin
      rx_level_reached <= (AW+1)'(trigger) <= rx_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Modem lines, order cts, dsr, ri, dcd.

  logic [3:0] modem_now;
  logic [3:0] modem_set;
  logic       msr_read;

  assign modem_now = {dcd, ri, dsr, cts};
  assign modem_set = {modem_now[3] ^ modem_q[3], modem_q[2] && !modem_now[2],
                      modem_now[1:0] ^ modem_q[1:0]};
  assign msr_read  = rd_hit && off == `SPU_OFF_MSR;

  // A change seen in the clearing cycle survives the read.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      modem_q   <= 4'h0;
      msr_delta <= 4'h0;
    end else begin
      modem_q   <= modem_now;
      msr_delta <= (msr_read ? 4'h0 : msr_delta) | modem_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data.

  logic [7:0] line_status;
  logic [7:0] rd_mux;
  logic       thre;
  logic       temt;

  assign thre = tx_count == '0;
  assign temt = thre && !tx_busy && !tx_start;
  assign line_status  = {|err_vec, temt, thre, rx_head.bi, rx_head.fe, rx_head.pe, overrun, rx_count != '0};

  always_comb begin
    case (off)
      `SPU_OFF_DATA: rd_mux = divisor_access_select ? div[7:0] : rx_head.data;
      `SPU_OFF_IER:  rd_mux = divisor_access_select ? div[15:8] : ier;
      `SPU_OFF_LCR:  rd_mux = line_control;
      `SPU_OFF_MCR:  rd_mux = modem_control;
      `SPU_OFF_LSR:  rd_mux = line_status;
      `SPU_OFF_MSR:  rd_mux = {modem_now, msr_delta};
      `SPU_OFF_SCRATCH: rd_mux = scratch;
      default:       rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      io_rdata <= 8'h00;
    end else if (rd_hit) begin
      io_rdata <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  chk_divisor_low_read: assert property (rd_hit && off == `SPU_OFF_DATA && divisor_access_select |=>
    io_rdata == $past(div[7:0])) else $error("divisor low byte read wrong");
  chk_divisor_high_read: assert property (rd_hit && off == `SPU_OFF_IER && divisor_access_select |=>
    io_rdata == $past(div[15:8])) else $error("divisor high byte read wrong");
  chk_scratch_readback: assert property (wr_hit && off == `SPU_OFF_SCRATCH ##1
    !(wr_hit && off == `SPU_OFF_SCRATCH) ##1
    rd_hit && off == `SPU_OFF_SCRATCH && !wr_hit |=> io_rdata == $past(io_wdata, 3))
    else $error("scratch byte lost");
  chk_holding_empty: assert property (rd_hit && off == `SPU_OFF_LSR |=>
    io_rdata[`SPU_LSR_THRE] == $past(tx_count == '0)) else $error("holding empty flag wrong");
  chk_shift_empty: assert property (rd_hit && off == `SPU_OFF_LSR |=>
    !io_rdata[`SPU_LSR_TEMT] || $past(tx_count == '0 && !tx_busy))
    else $error("shift empty flag wrong");
  chk_ring_trailing: assert property (!msr_read && $fell(ri) |=> msr_delta[2])
    else $error("ring trailing edge missed");
  chk_delta_clear: assert property (msr_read && modem_set == 4'h0 |=> msr_delta == 4'h0)
    else $error("modem deltas not cleared");
  chk_break_forces: assert property (line_control[`SPU_LCR_BREAK] |=> !serial_out)
    else $error("break not driven");
  chk_overrun_set: assert property (rx_valid && rx_count == limit && !rx_clear && !rx_pop |=>
    overrun && $stable(rx_count)) else $error("overrun not flagged");
  chk_rx_clear: assert property (rx_clear |=> rx_count == '0)
    else $error("receive FIFO not emptied");
  chk_dtr_follow: assert property (wr_hit && off == `SPU_OFF_MCR |=>
    dtr == $past(io_wdata[`SPU_MCR_DTR]) && rts == $past(io_wdata[`SPU_MCR_RTS]))
    else $error("modem control outputs wrong");

  cov_tx_char:   cover property (tx_push ##[1:8] tx_start);
  cov_rx_char:   cover property (rx_push ##[1:8] rx_pop);
  cov_rx_error:  cover property (rx_push && (rx_char.pe || rx_char.fe));
  cov_fifo_full: cover property (rx_count == limit && fifo_control[`SPU_FCR_ENABLE]);

endmodule
`default_nettype wire

/* File: test/spu_remote.sv */
/*
  Remote serial equipment: sends and receives eight-bit characters, no parity, one stop bit.
  Assumes a 10 ns bench clock and a serial line that idles high.
*/
`timescale 1ns/10ps
`default_nettype none
module spu_remote #(
  parameter int BIT = 868
)(
  input  wire logic  line_in,
  output logic       line_out,
  output logic [7:0] got,
  output int         got_count
);
  initial begin
    line_out  = 1'b1;
    got       = 8'h00;
    got_count = 0;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic send(input logic [7:0] b);
    line_out = 1'b0;
    #(BIT*10);
    for (int i = 0; i < 8; i++) begin
      line_out = b[i];
      #(BIT*10);
    end
    line_out = 1'b1;
    #(BIT*10);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Sampling mid-bit lets the two ends drift by a few clocks without harm.
  initial begin
    forever begin
      wait (line_in === 1'b0);
      #(BIT*15);
      for (int i = 0; i < 8; i++) begin
        got[i] = line_in;
        #(BIT*10);
      end
      if (line_in === 1'b1) got_count++;
    end
  end
endmodule
`default_nettype wire

/* File: test/spu_serial_port_bench.sv */
/*
  Self-checking bench of the serial port register block with a remote serial partner.
  Assumes divisor 1, so one bit lasts 868 clocks, and the base switch set to 7'h7f.
*/
`timescale 1ns/10ps
`default_nettype none
module spu_serial_port_bench;
  typedef struct packed {logic wr; logic [2:0] off; logic [7:0] data;} spu_row_type;
  logic       clock, rst_b, io_wr, io_rd, serial_in, serial_out;
  logic       cts, dsr, ri, dcd, dtr, rts, rx_level_reached;
  logic [6:0] bsel;
  logic [2:0] off;
  logic [7:0] io_wdata, io_rdata, q, got;
  int         failures, tests_run, got_count, n;
  spu_row_type rows [19] = '{
    '{0,3,8'h00}, '{0,4,8'h00}, '{0,1,8'h00}, '{0,2,8'h00}, '{0,5,8'h60},
    '{1,7,8'ha5}, '{0,7,8'ha5}, '{1,1,8'hff}, '{0,1,8'h0f}, '{1,4,8'h03},
    '{1,3,8'h80}, '{0,0,8'h0c}, '{0,1,8'h00}, '{1,0,8'h01}, '{1,1,8'h00},
    '{0,0,8'h01}, '{1,3,8'h03}, '{0,1,8'h0f}, '{1,2,8'hc1}};
  spu_serial_port spu_serial_port_inst (.clock(clock), .rst_b(rst_b), .io_addr({bsel, off}),
    .base_switch(7'h7f), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .serial_in(serial_in), .serial_out(serial_out), .cts(cts), .dsr(dsr), .ri(ri), .dcd(dcd),
    .dtr(dtr), .rts(rts), .rx_level_reached(rx_level_reached));
  spu_remote spu_remote_inst (.line_in(serial_out), .line_out(serial_in), .got(got),
    .got_count(got_count));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic bus(input logic wr, input logic [2:0] o, input logic [7:0] d);
    @(negedge clock);
    off      = o;
    io_wr    = wr;
    io_rd    = ~wr;
    io_wdata = d;
    @(negedge clock);
    io_wr = 1'b0;
    io_rd = 1'b0;
    q     = io_rdata;
  endtask
  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic rd(input string name, input logic [2:0] o, input logic [7:0] e);
    bus(1'b0, o, 8'h00);
    chk(name, e, q);
  endtask
  task automatic report_and_stop;
    $display("counts: %0d compared, %0d mismatched", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // The longest path is one character each way, about 20000 clocks.
  initial begin
    #800000;
    failures++;
    report_and_stop;
  end
  initial begin
    {rst_b, io_wr, io_rd, io_wdata, cts, dsr, ri, dcd} = '0;
    bsel = 7'h7f;
    off  = 3'h0;
    failures  = 0;
    tests_run = 0;
    repeat (2) @(negedge clock);
    rst_b = 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) bus(1'b1, rows[i].off, rows[i].data);
      else rd("row", rows[i].off, rows[i].data);
    end
    chk("dtr_rts", 8'h03, {6'h00, rts, dtr});
    $display("test registers done");
    bsel = 7'h00;
    bus(1'b1, 3'h7, 8'h3c);
    bsel = 7'h7f;
    rd("other_base", 3'h7, 8'ha5);
    $display("test decode done");
    bus(1'b1, 3'h0, 8'h5a);
    bus(1'b0, 3'h5, 8'h00);
    chk("shift_busy", 8'h00, q & 8'h40);
    n = 0;
    while (got_count == 0 && n < 12000) begin
      @(negedge clock);
      n++;
    end
    chk("tx_char", 8'h5a, got);
    // The partner counts the character half a bit before the stop bit ends.
    repeat (500) @(negedge clock);
    rd("tx_idle", 3'h5, 8'h60);
    $display("test transmit done");
    spu_remote_inst.send(8'h3c);
    repeat (20) @(negedge clock);
    // The trigger level is 14, so one character must not reach it.
    chk("level", 8'h00, {7'h00, rx_level_reached});
    rd("rx_ready", 3'h5, 8'h61);
    rd("rx_char", 3'h0, 8'h3c);
    rd("rx_empty", 3'h5, 8'h60);
    $display("test receive done");
    {cts, dsr, ri, dcd} = 4'b1011;
    repeat (3) @(negedge clock);
    rd("modem_delta", 3'h6, 8'hd9);
    rd("modem_clear", 3'h6, 8'hd0);
    ri = 1'b0;
    repeat (3) @(negedge clock);
    rd("ring_trail", 3'h6, 8'h94);
    $display("test modem done");
    bus(1'b1, 3'h3, 8'h43);
    repeat (2) @(negedge clock);
    chk("break", 8'h00, {7'h00, serial_out});
    $display("test break done");
    report_and_stop;
  end
endmodule
`default_nettype wire
